// ===== sdram_pkg.sv
// Shared constants for the SDRAM device model and its controller.
package sdram_pkg;
  // Bus geometry.
  localparam int DQ_W  = 16;
  localparam int BA_W  = 2;
  localparam int A_W   = 13;
  localparam int ROW_W = 13;
  localparam int COL_W = 10;
  localparam int NBANK = 4;
  // Command codes as {cs_n, ras_n, cas_n, we_n}.
  localparam logic [3:0] CMD_MRS = 4'h0;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_WR  = 4'h4;
  localparam logic [3:0] CMD_RD  = 4'h5;
  localparam logic [3:0] CMD_BST = 4'h6;
  localparam logic [3:0] CMD_NOP = 4'h7;
  // Mode word fields on the address pins, and the auto precharge pin.
  localparam int MODE_BL_LSB = 0;
  localparam int MODE_BT_BIT = 3;
  localparam int MODE_CL_LSB = 4;
  localparam int AP_BIT      = 10;
  localparam logic [2:0] BL_FULL = 3'h7;
  localparam logic [2:0] CL_THREE = 3'h3;
  localparam logic [2:0] CL_TWO   = 3'h2;
  localparam logic [2:0] RST_BL = 3'h0;
  localparam logic [2:0] RST_CL = 3'h3;
  // Timing at the 20 MHz system clock.
  localparam int T_CLK_NS   = 50;
  localparam int T_RAS_NS   = 40;
  localparam int T_RC_NS    = 55;
  localparam int REF_WIN_NS = 64_000_000;
  localparam int REF_OPS    = 8192;
  localparam int RAS_CYC  = (T_RAS_NS + T_CLK_NS - 1) / T_CLK_NS;
  localparam int RC_CYC   = (T_RC_NS + T_CLK_NS - 1) / T_CLK_NS;
  localparam int REFI_CYC = REF_WIN_NS / REF_OPS / T_CLK_NS;
  localparam int REFI_W = 8;
  localparam int CNT_W  = 4;
  // Controller register map (word index) and fields.
  localparam logic [2:0] REG_CTRL   = 3'h0;
  localparam logic [2:0] REG_ADDR   = 3'h1;
  localparam logic [2:0] REG_WDATA  = 3'h2;
  localparam logic [2:0] REG_RDATA  = 3'h3;
  localparam logic [2:0] REG_STATUS = 3'h4;
  localparam int CTRL_GO = 0;
  localparam int CFG_LSB = 1;
  localparam int CFG_W   = 8;
  localparam int CF_WR = 0;
  localparam int CF_AP = 1;
  localparam int CF_BL = 2;
  localparam int CF_CL3 = 4;
  localparam int CF_IL = 5;
  localparam int CF_PD = 6;
  localparam int CF_SR = 7;
  localparam logic [7:0] CFG_MODE_MASK = 8'h3C;
  localparam logic [7:0] CFG_RST = 8'h10;
  localparam int ADR_COL = 0;
  localparam int ADR_ROW = 10;
  localparam int ADR_BANK = 23;
  localparam int FIFO_DEPTH = 16;
endpackage

// ===== sdram_if.sv
// Pin bundle between the SDRAM controller and the SDRAM device.
`timescale 1ns/1ps
`default_nettype none
interface sdram_if;
  import sdram_pkg::*;
  logic            cke;
  logic            cs_n;
  logic            ras_n;
  logic            cas_n;
  logic            we_n;
  logic [BA_W-1:0] ba;
  logic [A_W-1:0]  addr;
  logic [1:0]      dqm;
  logic [DQ_W-1:0] ctl_dq;
  logic            ctl_dq_oe;
  logic [DQ_W-1:0] mem_dq;
  logic            mem_dq_oe;
  logic [DQ_W-1:0] dq;
  // Resolved data bus level; the device wins while it drives.
  assign dq = mem_dq_oe ? mem_dq : ctl_dq;
  modport mem (input cke, cs_n, ras_n, cas_n, we_n, ba, addr, dqm, dq,
               output mem_dq, mem_dq_oe);
  modport ctl (output cke, cs_n, ras_n, cas_n, we_n, ba, addr, dqm, ctl_dq, ctl_dq_oe,
               input dq);
endinterface
`default_nettype wire

// ===== sdram_mem.sv
// Device end: four-bank 16-bit synchronous DRAM with its burst engine.
//
// Notes on behaviour
// - Inputs taken on rising clock edge only.
// - Burst column steps each edge; registered outputs.
// - Four banks of 8M sixteen-bit words.
// - Controller activates a row before access.
// - Bursts of 1,2,4,8 or page; stoppable.
// - Sequential or interleaved column order.
// - Read latency of two or three cycles.
// - Auto precharge closes row after burst.
// - Controller refreshes 8192 times per 64 ms.
// - Auto refresh and self refresh supported.
// - Row stays open at least 40 ns.
// - Same-bank activates at least 55 ns apart.
// - Power-down entered and left through CKE.
// - CKE low freezes internal clock next cycle.
// - Power-down only while all banks idle.
`timescale 1ns/1ps
`default_nettype none
module sdram_mem
  import sdram_pkg::*;
#(
  parameter int ROWS_W = ROW_W,
  parameter int COLS_W = COL_W
) (
  // Clock and reset.
  input  wire logic clk_sys,
  input  wire logic nrst,
  // Pins from the controller.
  sdram_if.mem      bus,
  // Device status.
  output logic      power_down,
  output logic      self_refresh,
  output logic      refresh_pulse,
  output logic      burst_busy
);
  localparam int MA_W  = BA_W + ROWS_W + COLS_W;
  localparam int WORDS = NBANK << (ROWS_W + COLS_W);

  typedef struct packed {
    logic                         cke_q;
    logic [2:0]                   bl;
    logic                         bt;
    logic [2:0]                   cl;
    logic [NBANK-1:0]             open;
    logic [NBANK-1:0][ROWS_W-1:0] row;
    logic                         act;
    logic                         wr;
    logic                         ap;
    logic [BA_W-1:0]              bank;
    logic [COLS_W-1:0]            base;
    logic [COLS_W-1:0]            idx;
    logic [1:0]                   pv;
    logic [1:0][DQ_W-1:0]         pd;
    logic                         dq_oe;
    logic [DQ_W-1:0]              dq;
    logic                         pdn;
    logic                         sref;
    logic [REFI_W-1:0]            refi;
    logic                         ref_p;
  } mem_state_t;

  mem_state_t        state_r;
  mem_state_t        state_nxt;
  logic [DQ_W-1:0]   cells [0:WORDS-1];
  logic [3:0]        cmd;
  logic              run;
  logic              full;
  logic              start;
  logic              go;
  logic              last;
  logic              wr;
  logic              ap;
  logic [BA_W-1:0]   bank;
  logic [COLS_W-1:0] msk;
  logic [COLS_W-1:0] base;
  logic [COLS_W-1:0] idx;
  logic [COLS_W-1:0] ord;
  logic [COLS_W-1:0] col;
  logic [MA_W-1:0]   maddr;

  // Decode of the current access; a new read or write overrides a running burst.
  always_comb begin
    cmd   = {bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n};
    run   = state_r.cke_q && !state_r.pdn && !state_r.sref;
    full  = (state_r.bl == BL_FULL);
    msk   = full ? '1 : ((COLS_W'(1) << state_r.bl[1:0]) - COLS_W'(1));
    start = run && (cmd == CMD_RD || cmd == CMD_WR) && state_r.open[bus.ba];
    go    = start || (run && state_r.act && cmd != CMD_BST);
    bank  = start ? bus.ba : state_r.bank;
    base  = start ? bus.addr[COLS_W-1:0] : state_r.base;
    idx   = start ? '0 : state_r.idx;
    wr    = start ? (cmd == CMD_WR) : state_r.wr;
    ap    = start ? bus.addr[AP_BIT] : state_r.ap;
    // Interleave has no meaning over a full page, so the page wraps in order.
    ord   = (state_r.bt && !full) ? (base ^ idx) : (base + idx);
    col   = (base & ~msk) | (ord & msk);
    maddr = {bank, state_r.row[bank], col};
    last  = !full && (idx == msk);
  end

  // Next state of the command decoder, burst engine and power states.
  always_comb begin
    state_nxt       = state_r;
    state_nxt.cke_q = bus.cke;
    state_nxt.ref_p = 1'b0;
    if (state_r.pdn || state_r.sref) begin
      // Only the clock gate is watched while powered down.
      if (bus.cke) begin
        state_nxt.pdn  = 1'b0;
        state_nxt.sref = 1'b0;
      end
      if (state_r.sref) begin
        if (state_r.refi == '0) begin
          state_nxt.refi  = REFI_W'(REFI_CYC - 1);
          state_nxt.ref_p = 1'b1;
        end else begin
          state_nxt.refi = state_r.refi - 1'b1;
        end
      end
    end else if (run) begin
      // Read pipeline: the output register picks the stage for the latency.
      state_nxt.pv    = {state_r.pv[0], 1'b0};
      state_nxt.pd    = {state_r.pd[0], {DQ_W{1'b0}}};
      state_nxt.dq    = (state_r.cl == CL_THREE) ? state_r.pd[1] : state_r.pd[0];
      state_nxt.dq_oe = (state_r.cl == CL_THREE) ? state_r.pv[1] : state_r.pv[0];
      if (go) begin
        if (!wr) begin
          state_nxt.pv[0] = 1'b1;
          state_nxt.pd[0] = cells[maddr];
        end
        state_nxt.bank = bank;
        state_nxt.base = base;
        state_nxt.wr   = wr;
        state_nxt.ap   = ap;
        state_nxt.idx  = idx + 1'b1;
        state_nxt.act  = !last;
        if (last && ap) begin
          state_nxt.open[bank] = 1'b0;
        end
      end else if (cmd == CMD_BST) begin
        state_nxt.act = 1'b0;
      end
      case (cmd)
        CMD_ACT: begin
          state_nxt.open[bus.ba] = 1'b1;
          state_nxt.row[bus.ba]  = bus.addr[ROWS_W-1:0];
        end
        CMD_PRE: begin
          if (bus.addr[AP_BIT]) begin
            state_nxt.open = '0;
          end else begin
            state_nxt.open[bus.ba] = 1'b0;
          end
        end
        CMD_REF: begin
          if (bus.cke) begin
            state_nxt.ref_p = 1'b1;
          end else if (state_r.open == '0) begin
            state_nxt.sref = 1'b1;
            state_nxt.refi = REFI_W'(REFI_CYC - 1);
          end
        end
        CMD_MRS: begin
          state_nxt.bl = bus.addr[MODE_BL_LSB +: 3];
          state_nxt.bt = bus.addr[MODE_BT_BIT];
          state_nxt.cl = bus.addr[MODE_CL_LSB +: 3];
        end
        default: begin
        end
      endcase
      // Dropping the gate with every bank idle and no burst is power-down.
      if (!bus.cke && cmd != CMD_REF && state_r.open == '0 && !state_nxt.act) begin
        state_nxt.pdn = 1'b1;
      end
    end
  end

  // State register; every pin is sampled only on the rising edge.
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      state_r <= '{bl: RST_BL, cl: RST_CL, refi: '0, default: '0};
    end else begin
      state_r <= state_nxt;
    end
  end

  // Array write with per-byte masks; no reset so the array maps to RAM.
  always_ff @(posedge clk_sys) begin
    if (go && wr && !bus.dqm[0]) begin
      cells[maddr][7:0] <= bus.dq[7:0];
    end
    if (go && wr && !bus.dqm[1]) begin
      cells[maddr][15:8] <= bus.dq[15:8];
    end
  end

  // Pins and status all come straight from the state register.
  assign bus.mem_dq    = state_r.dq;
  assign bus.mem_dq_oe = state_r.dq_oe;
  assign power_down    = state_r.pdn;
  assign self_refresh  = state_r.sref;
  assign refresh_pulse = state_r.ref_p;
  assign burst_busy    = state_r.act;
endmodule
`default_nettype wire

// ===== sdram_ctl.sv
// Controller end: Avalon-MM register front end, data FIFOs and SDRAM command sequencer.
`timescale 1ns/1ps
`default_nettype none
module sdram_fifo
  import sdram_pkg::*;
#(
  parameter int W = DQ_W,
  parameter int D = FIFO_DEPTH
) (
  // Clock and reset.
  input  wire logic            clk_sys,
  input  wire logic            nrst,
  // Filling side.
  input  wire logic            in_valid,
  output logic                 in_ready,
  input  wire logic [W-1:0]    in_data,
  // Draining side.
  output logic                 out_valid,
  input  wire logic            out_ready,
  output logic [W-1:0]         out_data,
  output logic [$clog2(D):0]   level
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } fifo_state_t;
  fifo_state_t  state_r;
  fifo_state_t  state_nxt;
  logic [W-1:0] cells [0:D-1];
  logic         push;
  logic         pop;

  // Flags come from the count, so full and empty are exact.
  assign in_ready  = (state_r.cnt != (AW+1)'(D));
  assign out_valid = (state_r.cnt != '0);
  assign out_data  = cells[state_r.rp];
  assign level     = state_r.cnt;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Pointer and count update.
  always_comb begin
    state_nxt     = state_r;
    state_nxt.wp  = push ? state_r.wp + 1'b1 : state_r.wp;
    state_nxt.rp  = pop ? state_r.rp + 1'b1 : state_r.rp;
    state_nxt.cnt = state_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Storage holds no reset.
  always_ff @(posedge clk_sys) begin
    if (push) begin
      cells[state_r.wp] <= in_data;
    end
  end
endmodule

module sdram_ctl
  import sdram_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  // Pins to the SDRAM.
  sdram_if.ctl             bus,
  // Avalon-MM slave.
  input  wire logic [2:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest
);
  typedef enum logic [3:0] {
    S_IDLE, S_PREA, S_MRS, S_REF, S_PRE, S_ACT, S_RW, S_BURST, S_DRAIN, S_PD, S_SR
  } ctl_st_t;

  typedef struct packed {
    ctl_st_t                     st;
    ctl_st_t                     tgt;
    logic [3:0]                  cmd;
    logic                        cke;
    logic [BA_W-1:0]             ba;
    logic [A_W-1:0]              addr;
    logic [DQ_W-1:0]             dq;
    logic                        dq_oe;
    logic [NBANK-1:0]            open;
    logic [NBANK-1:0][ROW_W-1:0] row;
    logic [CFG_W-1:0]            cfg;
    logic                        dirty;
    logic                        go;
    logic [24:0]                 target;
    logic [3:0]                  left;
    logic [2:0]                  cw;
    logic [3:0]                  cap;
    logic [REFI_W-1:0]           refi;
    logic                        ref_due;
    logic [CNT_W-1:0]            rc;
    logic [CNT_W-1:0]            ras;
    logic                        rack;
    logic [31:0]                 rdata;
  } ctl_state_t;

  ctl_state_t      s;
  ctl_state_t      n;
  logic            wf_ready;
  logic            wf_valid;
  logic [DQ_W-1:0] wf_data;
  logic [4:0]      wf_level;
  logic            rf_valid;
  logic [DQ_W-1:0] rf_data;
  logic [4:0]      rf_level;
  logic            wpush;
  logic            wpop;
  logic            rpush;
  logic            rpop;
  logic [3:0]      len;
  logic [BA_W-1:0] tb;
  logic [ROW_W-1:0] trow;
  logic            room;

  sdram_fifo #(.W(DQ_W), .D(FIFO_DEPTH)) wfifo (
    .clk_sys(clk_sys), .nrst(nrst),
    .in_valid(wpush), .in_ready(wf_ready), .in_data(avs_writedata[DQ_W-1:0]),
    .out_valid(wf_valid), .out_ready(wpop), .out_data(wf_data), .level(wf_level)
  );

  // Room was reserved before the read, so this fill side never stalls.
  sdram_fifo #(.W(DQ_W), .D(FIFO_DEPTH)) rfifo (
    .clk_sys(clk_sys), .nrst(nrst),
    .in_valid(rpush), .in_ready(), .in_data(bus.dq),
    .out_valid(rf_valid), .out_ready(rpop), .out_data(rf_data), .level(rf_level)
  );

  // Bus handshake: reads take one wait state, data writes stall on a full FIFO.
  always_comb begin
    len   = 4'(1) << s.cfg[CF_BL +: 2];
    tb    = s.target[ADR_BANK +: BA_W];
    trow  = s.target[ADR_ROW +: ROW_W];
    room  = s.cfg[CF_WR] ? (wf_level >= 5'(len)) : (6'(rf_level) + 6'(len) <= 6'(FIFO_DEPTH));
    wpush = avs_write && avs_address == REG_WDATA;
    rpop  = avs_read && !s.rack && avs_address == REG_RDATA;
    avs_waitrequest = (avs_read && !s.rack) || (wpush && !wf_ready);
    wpop  = (s.st == S_RW || s.st == S_BURST) && s.cfg[CF_WR] && wf_valid;
    rpush = (s.cw == 3'h1);
  end

  // Command sequencer, refresh timer and register file.
  always_comb begin
    n       = s;
    n.cmd   = CMD_NOP;
    n.dq_oe = 1'b0;
    n.rc    = (s.rc != '0) ? s.rc - 1'b1 : s.rc;
    n.ras   = (s.ras != '0) ? s.ras - 1'b1 : s.ras;
    case (s.st)
      S_IDLE: begin
        if (s.ref_due) begin
          n.tgt = S_REF;
          n.st  = S_PREA;
        end else if (s.dirty) begin
          n.tgt = S_MRS;
          n.st  = S_PREA;
        end else if (s.cfg[CF_SR]) begin
          n.tgt = S_SR;
          n.st  = S_PREA;
        end else if (s.cfg[CF_PD]) begin
          n.tgt = S_PD;
          n.st  = S_PREA;
        end else if (s.go && room) begin
          n.go = 1'b0;
          // Reuse an open row, close and reopen on another row, or just open a closed bank.
          if (s.open[tb] && s.row[tb] == trow) begin
            n.st = S_RW;
          end else if (s.open[tb]) begin
            n.st = S_PRE;
          end else begin
            n.st = S_ACT;
          end
        end
      end
      S_PREA: begin
        if (s.ras == '0) begin
          n.cmd          = CMD_PRE;
          n.addr[AP_BIT] = 1'b1;
          n.open         = '0;
          n.st           = s.tgt;
        end
      end
      S_MRS: begin
        n.cmd  = CMD_MRS;
        n.addr = '0;
        n.addr[MODE_BL_LSB +: 3] = {1'b0, s.cfg[CF_BL +: 2]};
        n.addr[MODE_BT_BIT]      = s.cfg[CF_IL];
        n.addr[MODE_CL_LSB +: 3] = s.cfg[CF_CL3] ? CL_THREE : CL_TWO;
        n.dirty = 1'b0;
        n.st    = S_IDLE;
      end
      S_REF: begin
        if (s.rc == '0) begin
          n.cmd     = CMD_REF;
          n.rc      = CNT_W'(RC_CYC - 1);
          n.ref_due = 1'b0;
          n.st      = S_IDLE;
        end
      end
      S_PRE: begin
        if (s.ras == '0) begin
          n.cmd          = CMD_PRE;
          n.ba           = tb;
          n.addr[AP_BIT] = 1'b0;
          n.open[tb]     = 1'b0;
          n.st           = S_ACT;
        end
      end
      S_ACT: begin
        if (s.rc == '0) begin
          n.cmd      = CMD_ACT;
          n.ba       = tb;
          n.addr     = trow;
          n.open[tb] = 1'b1;
          n.row[tb]  = trow;
          n.rc       = CNT_W'(RC_CYC - 1);
          n.ras      = CNT_W'(RAS_CYC - 1);
          n.st       = S_RW;
        end
      end
      S_RW: begin
        n.cmd  = s.cfg[CF_WR] ? CMD_WR : CMD_RD;
        n.ba   = tb;
        n.addr = {2'b00, s.cfg[CF_AP], s.target[ADR_COL +: COL_W]};
        n.left = len - 4'h1;
        if (s.cfg[CF_AP]) begin
          n.open[tb] = 1'b0;
        end
        if (s.cfg[CF_WR]) begin
          n.dq    = wf_data;
          n.dq_oe = 1'b1;
        end else begin
          // One count more than the latency, since the command leaves the controller's state register one edge before the device samples it.
          n.cw  = s.cfg[CF_CL3] ? 3'h4 : 3'h3;
          n.cap = len;
        end
        n.st = (len == 4'h1) ? S_DRAIN : S_BURST;
      end
      S_BURST: begin
        if (s.cfg[CF_WR]) begin
          n.dq    = wf_data;
          n.dq_oe = 1'b1;
        end
        n.left = s.left - 4'h1;
        n.st   = (s.left == 4'h1) ? S_DRAIN : S_BURST;
      end
      S_DRAIN: begin
        if (s.cw == '0) begin
          n.st = S_IDLE;
        end
      end
      S_PD: begin
        n.cke = !s.cfg[CF_PD];
        n.st  = s.cfg[CF_PD] ? S_PD : S_IDLE;
      end
      S_SR: begin
        if (s.cke && s.cfg[CF_SR]) begin
          n.cmd = CMD_REF;
          n.cke = 1'b0;
        end else if (!s.cfg[CF_SR]) begin
          n.cke  = 1'b1;
          n.refi = REFI_W'(REFI_CYC - 1);
          n.st   = S_IDLE;
        end
      end
      default: begin
        n.st = S_IDLE;
      end
    endcase
    // Read capture counts down to the latency edge, then takes one word per edge.
    if (s.cw > 3'h1) begin
      n.cw = s.cw - 3'h1;
    end else if (rpush) begin
      n.cap = s.cap - 4'h1;
      n.cw  = (s.cap == 4'h1) ? 3'h0 : 3'h1;
    end
    // Refresh interval timer; the due flag is set after any clear so it wins.
    if (s.st != S_SR) begin
      if (s.refi == '0) begin
        n.refi    = REFI_W'(REFI_CYC - 1);
        n.ref_due = 1'b1;
      end else begin
        n.refi = s.refi - 1'b1;
      end
    end
    // Register reads land one edge after the request.
    n.rack = avs_read && !s.rack;
    if (avs_read && !s.rack) begin
      case (avs_address)
        REG_CTRL:   n.rdata = 32'({s.cfg, 1'b0});
        REG_ADDR:   n.rdata = 32'(s.target);
        REG_RDATA:  n.rdata = rf_valid ? 32'(rf_data) : 32'h0000_0000;
        REG_STATUS: n.rdata = 32'({rf_level, wf_level, s.open, s.st == S_SR, s.st == S_PD,
                                   s.st != S_IDLE || s.go});
        default:    n.rdata = 32'h0000_0000;
      endcase
    end
    // Register writes; a new start request wins over its own clear.
    if (avs_write && avs_address == REG_CTRL) begin
      n.cfg = avs_writedata[CFG_LSB +: CFG_W];
      if (((avs_writedata[CFG_LSB +: CFG_W] ^ s.cfg) & CFG_MODE_MASK) != '0) begin
        n.dirty = 1'b1;
      end
      if (avs_writedata[CTRL_GO]) begin
        n.go = 1'b1;
      end
    end
    if (avs_write && avs_address == REG_ADDR) begin
      n.target = avs_writedata[24:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      s <= '{st: S_IDLE, tgt: S_IDLE, cmd: CMD_NOP, cke: 1'b1, cfg: CFG_RST, dirty: 1'b1,
             refi: REFI_W'(REFI_CYC - 1), default: '0};
    end else begin
      s <= n;
    end
  end

  // Every pin but dqm, which is tied low, is launched from the state register on the rising edge.
  assign bus.cke       = s.cke;
  assign bus.cs_n      = s.cmd[3];
  assign bus.ras_n     = s.cmd[2];
  assign bus.cas_n     = s.cmd[1];
  assign bus.we_n      = s.cmd[0];
  assign bus.ba        = s.ba;
  assign bus.addr      = s.addr;
  assign bus.dqm       = 2'b00;
  assign bus.ctl_dq    = s.dq;
  assign bus.ctl_dq_oe = s.dq_oe;
  assign avs_readdata  = s.rdata;
endmodule
`default_nettype wire

// ===== sdram_link_properties.sv
// Link checks between the SDRAM controller and device ends.
`timescale 1ns/1ps
`default_nettype none
module sdram_link_properties
  import sdram_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic nrst,
  // Link pins.
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic ctl_dq_oe,
  input wire logic mem_dq_oe
);
  logic [3:0] cmd;
  logic [9:0] ref_gap_r;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // Command code as the device decodes it.
  assign cmd = {cs_n, ras_n, cas_n, we_n};
  // Cycles since the last refresh; a gated clock restarts the count, in power-down as well as in self refresh, where the device refreshes itself.
  always_ff @(posedge clk_sys) begin
    if (!nrst || !cke || cmd == CMD_REF) begin
      ref_gap_r <= '0;
    end else begin
      ref_gap_r <= ref_gap_r + 10'h001;
    end
  end
  // Protocol checks; read latency is allowed either setting since the mode is not tracked here.
  idle_reset_a: assert property ($past(!nrst) |-> cke && cmd == CMD_NOP)
    else $error("Link busy after reset.");
  bus_excl_a: assert property (!(ctl_dq_oe && mem_dq_oe))
    else $error("Data bus clash.");
  act_rw_a: assert property (cmd == CMD_ACT |=> cmd == CMD_RD || cmd == CMD_WR)
    else $error("Activate without access.");
  wr_data_a: assert property (cmd == CMD_WR |-> ctl_dq_oe)
    else $error("Write without data.");
  act_space_a: assert property (cmd == CMD_ACT |=> cmd != CMD_ACT)
    else $error("Activates too close.");
  rd_lat_a: assert property (cmd == CMD_RD |-> ##[2:3] mem_dq_oe)
    else $error("Read data late.");
  rd_cause_a: assert property ($rose(mem_dq_oe) |-> $past(cmd, 2) == CMD_RD || $past(cmd, 3) == CMD_RD)
    else $error("Stray read data.");
  gate_idle_a: assert property ($fell(cke) |-> cmd == CMD_REF || $past(cmd) == CMD_PRE)
    else $error("Clock gated while open.");
  ref_gap_a: assert property (ref_gap_r < 10'h0C8)
    else $error("Refresh overdue.");
  act_hold_a: assert property (cmd == CMD_ACT |=> cmd != CMD_PRE)
    else $error("Row closed too soon.");
endmodule
`default_nettype wire

// ===== sdram_burst_access_core_bench.sv
// Bench joining the SDRAM controller and device ends.
`timescale 1ns/1ps
`default_nettype none
module sdram_burst_access_core_bench
  import sdram_pkg::*;
  ;
  logic        clk_sys;
  logic        nrst;
  logic [2:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [31:0] q;
  logic        power_down;
  logic        self_refresh;
  logic        refresh_pulse;
  logic        burst_busy;
  int          n_busy;
  int          n_ref;
  int          n_fail;
  int          tests_run;
  sdram_if sdram_if_i ();
  sdram_mem sdram_mem_i (.clk_sys, .nrst, .bus(sdram_if_i.mem), .power_down, .self_refresh,
    .refresh_pulse, .burst_busy);
  sdram_ctl sdram_ctl_i (.clk_sys, .nrst, .bus(sdram_if_i.ctl), .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest);
  sdram_link_properties sdram_link_properties_i (.clk_sys, .nrst, .cke(sdram_if_i.cke),
    .cs_n(sdram_if_i.cs_n), .ras_n(sdram_if_i.ras_n), .cas_n(sdram_if_i.cas_n), .we_n(sdram_if_i.we_n),
    .ctl_dq_oe(sdram_if_i.ctl_dq_oe), .mem_dq_oe(sdram_if_i.mem_dq_oe));
  // Burst continuation cycles and refresh pulses seen at the device, judged at the end.
  always @(posedge clk_sys) begin
    n_busy <= n_busy + int'(burst_busy === 1'h1);
    n_ref  <= n_ref + int'(refresh_pulse === 1'h1);
  end
  // Count a comparison and report a mismatch.
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // One Avalon transfer, held until waitrequest is seen low; the watchdog bounds a hang.
  task automatic av(input logic w, input logic [2:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do
      @(posedge clk_sys);
    while (avs_waitrequest !== 1'h0);
    q = avs_readdata;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
    @(posedge clk_sys);
  endtask
  // Read status until bit b shows v, then judge it.
  task automatic poll(input int b, input logic v);
    int k;
    k = 0;
    do begin
      av(1'h0, REG_STATUS, '0);
      k++;
    end while (q[b] !== v && k < 40);
    chk({31'h0, q[b]}, {31'h0, v});
  endtask
  // Write a burst, read it whole, then read one column to see the burst order.
  task automatic t_burst(input logic [4:0] m, input logic [1:0] bk, input logic [9:0] c, r, input int x);
    for (int i = 0; i < (1 << m[2:1]); i++)
      av(1'h1, REG_WDATA, {16'h0, 6'h30, bk, 8'(i)});
    av(1'h0, REG_STATUS, '0);
    chk({27'h0, q[11:7]}, 32'(1 << m[2:1]));
    av(1'h1, REG_ADDR, {7'h0, bk, 13'h0123, c});
    av(1'h1, REG_CTRL, {25'h0, m, 2'h3});
    poll(0, 1'h0);
    av(1'h1, REG_CTRL, {25'h0, m, 2'h1});
    poll(0, 1'h0);
    for (int i = 0; i < (1 << m[2:1]); i++) begin
      av(1'h0, REG_RDATA, '0);
      chk({16'h0, q[15:0]}, {16'h0, 6'h30, bk, 8'(i)});
    end
    av(1'h0, REG_STATUS, '0);
    chk({28'h0, q[6:3] & {4{m[0]}}}, '0);
    av(1'h1, REG_ADDR, {7'h0, bk, 13'h0123, r});
    av(1'h1, REG_CTRL, {25'h0, m[4:3], 5'h01});
    poll(0, 1'h0);
    av(1'h0, REG_RDATA, '0);
    chk({16'h0, q[15:0]}, {16'h0, 6'h30, bk, 8'(x)});
    $display("Burst test %h done", m);
  endtask
  // Enter and leave a low-power state: s is 1 for power-down, 2 for self refresh.
  task automatic t_power(input int s);
    av(1'h1, REG_CTRL, 32'h1 << (s + 6));
    poll(s, 1'h1);
    chk({30'h0, self_refresh, power_down}, 32'(s));
    av(1'h1, REG_CTRL, '0);
    poll(s, 1'h0);
    chk({30'h0, self_refresh, power_down}, 32'h0);
    $display("Power test %0d done", s);
  endtask
  // Print the counts and the verdict, then end the run.
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // System clock at 20 MHz.
  initial begin
    clk_sys = 1'h0;
    forever #25 clk_sys = !clk_sys;
  end
  // Watchdog of 20000 cycles, far above the five hundred or so the tests need.
  initial begin
    #1_000_000;
    n_fail++;
    stop_test();
  end
  // Reset, then the scenarios; power tests follow bursts that leave banks open.
  initial begin
    nrst = 1'h0;
    avs_address = 3'h0;
    avs_read = 1'h0;
    avs_write = 1'h0;
    avs_writedata = 32'h0;
    n_fail = 0;
    tests_run = 0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'h1;
    @(posedge clk_sys);
    t_burst(5'h01, 2'h0, 10'h9, 10'h9, 0);
    t_burst(5'h0A, 2'h1, 10'h3, 10'h2, 1);
    t_power(1);
    t_burst(5'h15, 2'h2, 10'h1, 10'h0, 1);
    t_burst(5'h0C, 2'h3, 10'h1, 10'h0, 3);
    t_power(2);
    t_burst(5'h07, 2'h0, 10'h5, 10'h4, 7);
    t_burst(5'h1E, 2'h1, 10'h6, 10'h0, 6);
    chk(n_busy, 32'h2A);
    chk({31'h0, n_ref != 0}, 32'h1);
    stop_test();
  end
endmodule
`default_nettype wire
